//--- inc/flash_host_pkg.sv
package flash_host_pkg;
   // ----------------------------------------------------------------
   // timing, clock 25 MHz
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned RESET_BUSY_US = 25;
   localparam int unsigned RESET_IDLE_NS = 100;
   localparam int unsigned POWERUP_US = 60;
   localparam int unsigned RECOVERY_NS = 210;
   localparam int unsigned STROBE_NS = 60;
   localparam int unsigned STROBE_HIGH_NS = 35;
   localparam int unsigned ACCESS_NS = 120;
   localparam int unsigned RESET_BUSY_CYC =
      (RESET_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_IDLE_CYC =
      (RESET_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POWERUP_CYC =
      (POWERUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVERY_CYC =
      (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CYC =
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACCESS_CYC =
      (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned BYTE_W = 8;

   // ----------------------------------------------------------------
   // request kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_READ = 2'b00,
      OP_CMD_WRITE = 2'b01,
      OP_ARRAY_WRITE = 2'b10,
      OP_RESET = 2'b11
   } op_t;

   typedef enum logic [2:0] {
      ST_POWERUP = 3'b000,
      ST_RECOVER = 3'b001,
      ST_IDLE = 3'b010,
      ST_READ = 3'b011,
      ST_WRITE = 3'b100,
      ST_WRITE_HIGH = 3'b101,
      ST_RESET = 3'b110
   } state_t;
endpackage

//--- core/sync2.sv
`timescale 1ns/1ps
module sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_reg;
   logic [WIDTH-1:0] sync_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= '0;
         sync_reg <= '0;
      end else begin
         stage_reg <= async_in;
         sync_reg <= stage_reg;
      end
   end
   assign sync_out = sync_reg;
endmodule // sync2

//--- core/flash_bus_host.sv
`timescale 1ns/1ps
module flash_bus_host
   import flash_host_pkg::*;
#(
   parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
   parameter int unsigned RESET_BUSY_CYCLES = RESET_BUSY_CYC
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire flash_host_pkg::op_t req_op,
   input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] req_wdata,
   input wire logic byte_mode,
   output logic req_ready,
   output logic rsp_valid,
   output logic [flash_host_pkg::DATA_W-1:0] rsp_rdata,
   output logic device_busy,
   output logic [flash_host_pkg::ADDR_W-1:0] addr,
   input wire logic [flash_host_pkg::DATA_W-1:0] data_in,
   output logic [flash_host_pkg::DATA_W-1:0] data_out,
   output logic data_oe_n,
   output logic chip_select_low,
   output logic chip_select_mid,
   output logic chip_select_high,
   output logic output_enable_n,
   output logic write_strobe_n,
   output logic reset_powerdown_n,
   output logic program_enable_supply,
   output logic byte_select,
   input wire logic status_pin
);
   import flash_host_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [DATA_W:0] sync_bus;
   logic sts_s;
   logic [DATA_W-1:0] din_s;
   sync2 #(.WIDTH(DATA_W + 1)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .async_in({status_pin, data_in}),
      .sync_out(sync_bus)
   );
   assign sts_s = sync_bus[DATA_W];
   assign din_s = sync_bus[DATA_W-1:0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic array_reg, array_next;
   logic byte_reg, byte_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic rsp_reg, rsp_next;
   logic ready_reg, ready_next;
   logic busy_reg, busy_next;
   logic dis_reg, dis_next;
   logic cs_reg, cs_next;
   logic sel_n_reg, sel_n_next;
   logic oe_n_reg, oe_n_next;
   logic we_n_reg, we_n_next;
   logic rp_n_reg, rp_n_next;
   logic program_enable_supply_reg, program_enable_supply_next;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = CNT_W'(n - 1);
   endfunction

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      array_next = array_reg;
      byte_next = byte_reg;
      addr_next = addr_reg;
      dout_next = dout_reg;
      rdata_next = rdata_reg;
      rsp_next = 1'b0;
      ready_next = 1'b0;
      busy_next = ~sts_s;
      dis_next = dis_reg;
      cs_next = cs_reg;
      oe_n_next = 1'b1;
      we_n_next = 1'b1;
      rp_n_next = rp_n_reg;
      program_enable_supply_next = program_enable_supply_reg;
      unique case (state_reg)
         ST_POWERUP: begin
            rp_n_next = 1'b0;
            if (cnt_reg == '0) begin
               rp_n_next = 1'b1;
               cnt_next = cyc(RECOVERY_CYC);
               state_next = ST_RECOVER;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_RECOVER: begin
            // count only once status is also released
            if (!sts_s) begin
               cnt_next = cyc(RECOVERY_CYC);
            end else if (cnt_reg == '0) begin
               state_next = ST_IDLE;
               ready_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_IDLE: begin
            ready_next = 1'b1;
            // drop supply on the first idle cycle with status high; the new busy has not reached sts_s by then
            if (array_reg && sts_s) begin
               program_enable_supply_next = 1'b0;
               array_next = 1'b0;
            end
            if (req_valid && ready_reg) begin
               ready_next = 1'b0;
               addr_next = req_addr;
               byte_next = byte_mode;
               dout_next = byte_mode ? req_wdata
                  : {{(DATA_W-BYTE_W){1'b0}}, req_wdata[BYTE_W-1:0]};
               unique case (req_op)
                  OP_READ: begin
                     cs_next = 1'b1;
                     oe_n_next = 1'b0;
                     cnt_next = cyc(ACCESS_CYC);
                     state_next = ST_READ;
                  end
                  OP_CMD_WRITE, OP_ARRAY_WRITE: begin
                     cs_next = 1'b1;
                     dis_next = 1'b0;
                     we_n_next = 1'b0;
                     if (req_op == OP_ARRAY_WRITE) begin
                        program_enable_supply_next = 1'b1;
                        array_next = 1'b1;
                     end
                     cnt_next = cyc(STROBE_CYC);
                     state_next = ST_WRITE;
                  end
                  OP_RESET: begin
                     cs_next = 1'b0;
                     rp_n_next = 1'b0;
                     // busy device needs the long pulse
                     cnt_next = sts_s ? cyc(RESET_IDLE_CYC)
                        : cyc(RESET_BUSY_CYCLES);
                     program_enable_supply_next = 1'b0;
                     array_next = 1'b0;
                     state_next = ST_RESET;
                  end
               endcase
            end
         end
         ST_READ: begin
            oe_n_next = 1'b0;
            if (cnt_reg == '0) begin
               oe_n_next = 1'b1;
               cs_next = 1'b0;
               rdata_next = byte_reg ? din_s
                  : {{(DATA_W-BYTE_W){1'b0}}, din_s[BYTE_W-1:0]};
               rsp_next = 1'b1;
               ready_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_WRITE: begin
            we_n_next = 1'b0;
            if (cnt_reg == '0) begin
               we_n_next = 1'b1;
               cnt_next = cyc(STROBE_HIGH_CYC);
               state_next = ST_WRITE_HIGH;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_WRITE_HIGH: begin
            // data held one stage past the strobe rise
            cs_next = 1'b0;
            dis_next = 1'b1;
            if (cnt_reg == '0) begin
               rsp_next = 1'b1;
               ready_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         ST_RESET: begin
            rp_n_next = 1'b0;
            if (cnt_reg == '0) begin
               rp_n_next = 1'b1;
               cnt_next = cyc(RECOVERY_CYC);
               state_next = ST_RECOVER;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: state_next = ST_POWERUP;
      endcase
      // select pin registered in its own polarity, no gate after the flop
      sel_n_next = ~cs_next;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_POWERUP;
         cnt_reg <= CNT_W'(POWERUP_CYCLES - 1);
         array_reg <= 1'b0;
         byte_reg <= 1'b1;
         addr_reg <= '0;
         dout_reg <= '0;
         rdata_reg <= '0;
         rsp_reg <= 1'b0;
         ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         dis_reg <= 1'b1;
         cs_reg <= 1'b0;
         sel_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         rp_n_reg <= 1'b0;
         program_enable_supply_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         array_reg <= array_next;
         byte_reg <= byte_next;
         addr_reg <= addr_next;
         dout_reg <= dout_next;
         rdata_reg <= rdata_next;
         rsp_reg <= rsp_next;
         ready_reg <= ready_next;
         busy_reg <= busy_next;
         dis_reg <= dis_next;
         cs_reg <= cs_next;
         sel_n_reg <= sel_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         rp_n_reg <= rp_n_next;
         program_enable_supply_reg <= program_enable_supply_next;
      end
   end

   // upper selects tied low; lowest select low enables
   assign chip_select_high = 1'b0;
   assign chip_select_mid = 1'b0;
   assign chip_select_low = sel_n_reg;
   assign output_enable_n = oe_n_reg;
   assign write_strobe_n = we_n_reg;
   assign reset_powerdown_n = rp_n_reg;
   assign program_enable_supply = program_enable_supply_reg;
   assign byte_select = byte_reg;
   assign addr = addr_reg;
   assign data_out = dout_reg;
   assign data_oe_n = dis_reg;
   assign req_ready = ready_reg;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;
   assign device_busy = busy_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_strobe_excl: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !(!oe_n_reg && !we_n_reg))
      else $error("output enable and write strobe low together");
   chk_read_pins: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !oe_n_reg |-> cs_reg && we_n_reg && rp_n_reg && dis_reg)
      else $error("read without select or with write or reset");
   chk_read_hold: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $fell(oe_n_reg) |-> (!oe_n_reg && we_n_reg && rp_n_reg)[*3])
      else $error("read pulse too short or disturbed");
   chk_write_pins: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !we_n_reg |-> cs_reg && oe_n_reg && rp_n_reg && !dis_reg)
      else $error("write strobe without proper select");
   chk_write_width: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $fell(we_n_reg) |-> !we_n_reg[*2])
      else $error("write pulse too short");
   chk_array_supply: assert property (
      @(posedge mclk) disable iff (!reset_n)
      (!we_n_reg && array_reg) |-> program_enable_supply_reg)
      else $error("array write without program supply");
   chk_reset_pulse: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $fell(rp_n_reg) |-> !rp_n_reg[*3])
      else $error("reset pulse too short");
   chk_ready_recover: assert property (
      @(posedge mclk) disable iff (!reset_n)
      $rose(rp_n_reg) |-> !ready_reg[*6])
      else $error("ready before recovery time");
   chk_select_fixed: assert property (
      @(posedge mclk) disable iff (!reset_n)
      !rp_n_reg |-> !cs_reg && oe_n_reg && we_n_reg)
      else $error("pins active during reset");
   cov_read: cover property (@(posedge mclk) disable iff (!reset_n)
      $fell(oe_n_reg) ##[1:8] rsp_reg);
   cov_write: cover property (@(posedge mclk) disable iff (!reset_n)
      $fell(we_n_reg) ##[1:8] rsp_reg);
   cov_reset: cover property (@(posedge mclk) disable iff (!reset_n)
      state_reg == ST_IDLE ##1 $fell(rp_n_reg));
endmodule // flash_bus_host

//--- sim/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model #(
   parameter int unsigned BUSY_CYCLES = 12
) (
   input wire logic mclk,
   input wire logic [3:0] word_addr,
   input wire logic [15:0] bus_in,
   input wire logic chip_select_low,
   input wire logic chip_select_mid,
   input wire logic chip_select_high,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   input wire logic reset_powerdown_n,
   input wire logic program_enable_supply,
   input wire logic byte_select,
   output logic [15:0] dev_q,
   output logic dev_drive,
   output logic status_pin
);
   logic [15:0] mem [16];
   logic enabled;
   logic start_tog = 1'b0;
   logic seen_tog = 1'b0;
   int unsigned busy_cnt = 0;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   assign enabled = chip_select_high ? !(chip_select_mid && chip_select_low)
      : (!chip_select_mid && !chip_select_low);
   assign dev_drive = reset_powerdown_n && enabled && !output_enable_n;
   // upper lines in byte mode are not driven: show the inverse of the stored upper byte
   assign dev_q = byte_select ? mem[word_addr]
      : {~mem[word_addr][15:8], mem[word_addr][7:0]};
   // pull-up wins whenever the state machine is not running
   assign status_pin = (busy_cnt != 0) ? 1'b0 : 1'b1;
   // programming only clears bits; writes while busy or locked are lost
   always @(posedge write_strobe_n) begin
      if (reset_powerdown_n && enabled && output_enable_n &&
          program_enable_supply && busy_cnt == 0) begin
         if (byte_select)
            mem[word_addr] <= mem[word_addr] & bus_in;
         else
            mem[word_addr][7:0] <= mem[word_addr][7:0] & bus_in[7:0];
         start_tog <= ~start_tog;
      end
   end
   // timer keeps running while deselected, stops only in reset
   always @(posedge mclk or negedge reset_powerdown_n) begin
      if (!reset_powerdown_n) begin
         busy_cnt <= 0;
      end else if (start_tog != seen_tog) begin
         busy_cnt <= BUSY_CYCLES;
         seen_tog <= start_tog;
      end else if (busy_cnt != 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
endmodule // flash_device_model

//--- sim/async_flash_bus_control_tb.sv
`timescale 1ns/1ps
module async_flash_bus_control_tb;
   import flash_host_pkg::*;
   typedef struct {op_t op; logic [23:0] a; logic [15:0] d; logic bm;
      logic [15:0] e;} row_t;
   logic mclk, reset_n, req_valid, byte_mode, req_ready, rsp_valid;
   logic device_busy, data_oe_n, chip_select_low, chip_select_mid;
   logic chip_select_high, output_enable_n, write_strobe_n;
   logic reset_powerdown_n, program_enable_supply, byte_select, status_pin;
   logic dev_drive;
   op_t req_op;
   logic [ADDR_W-1:0] req_addr, addr;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, data_in, data_out, dev_q;
   logic [DATA_W-1:0] last_bus = 16'h0000;
   int n_errors = 0, cmp_count = 0, lowc = 0, need = 4, rec = 0, n;
   logic first = 1'b1, rp_prev = 1'b0, st_prev = 1'b1, rdy_prev = 1'b0;
   logic wait_rec = 1'b1;
   row_t rows[7] = '{
      '{OP_ARRAY_WRITE, 24'h2, 16'h1234, 1'b1, 16'h0},
      '{OP_READ, 24'h2, 16'h0, 1'b1, 16'h1234},
      '{OP_READ, 24'h2, 16'h0, 1'b0, 16'h0034},
      '{OP_CMD_WRITE, 24'h2, 16'hffff, 1'b1, 16'h0},
      '{OP_READ, 24'h2, 16'h0, 1'b1, 16'h1234},
      '{OP_ARRAY_WRITE, 24'h5, 16'h00a5, 1'b0, 16'h0},
      '{OP_READ, 24'h5, 16'h0, 1'b1, 16'hffa5}};

   flash_bus_host #(.POWERUP_CYCLES(4), .RESET_BUSY_CYCLES(4)) dut (
      .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .byte_mode(byte_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .device_busy(device_busy), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .chip_select_low(chip_select_low), .chip_select_mid(chip_select_mid),
      .chip_select_high(chip_select_high),
      .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .reset_powerdown_n(reset_powerdown_n),
      .program_enable_supply(program_enable_supply),
      .byte_select(byte_select), .status_pin(status_pin));

   flash_device_model dev (
      .mclk(mclk), .word_addr(addr[3:0]), .bus_in(data_in),
      .chip_select_low(chip_select_low), .chip_select_mid(chip_select_mid),
      .chip_select_high(chip_select_high),
      .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .reset_powerdown_n(reset_powerdown_n),
      .program_enable_supply(program_enable_supply),
      .byte_select(byte_select), .dev_q(dev_q), .dev_drive(dev_drive),
      .status_pin(status_pin));

   // undriven bus shows the inverse of its last value
   assign data_in = dev_drive ? dev_q : (!data_oe_n ? data_out : ~last_bus);
   always @(posedge mclk) last_bus <= data_in;

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic do_req(input row_t r);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      chk(req_ready, 1'b1);
      req_valid = 1'b1;
      req_op = r.op;
      req_addr = r.a;
      req_wdata = r.d;
      byte_mode = r.bm;
      @(negedge mclk);
      req_valid = 1'b0;
      if (r.op == OP_RESET) return;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 50) begin
         @(negedge mclk);
         k++;
      end
      chk(rsp_valid, 1'b1);
      chk(byte_select, r.bm);
      if (r.op == OP_READ) chk(rsp_rdata, r.e);
   endtask

   // ----------------------------------------------------------------
   // pin watch, sampled away from the launching edge
   // ----------------------------------------------------------------
   always @(negedge mclk) begin
      if (reset_n) begin
         chk(chip_select_mid | chip_select_high, 1'b0);
         chk(dev_drive & ~data_oe_n, 1'b0);
         if (!output_enable_n)
            chk({reset_powerdown_n, write_strobe_n, chip_select_low},
               3'b110);
         if (!write_strobe_n)
            chk({reset_powerdown_n, output_enable_n, chip_select_low,
               data_oe_n}, 4'b1100);
         if (!reset_powerdown_n && lowc == 0)
            need = first ? 3 : (st_prev ? RESET_IDLE_CYC : 4);
         if (!reset_powerdown_n) lowc++;
         if (reset_powerdown_n && !rp_prev && lowc > 0) begin
            chk(lowc >= need, 1'b1);
            first = 1'b0;
            lowc = 0;
         end
         rec = (!reset_powerdown_n || !status_pin) ? 0 : rec + 1;
         // only the first ready after a reset pulse owes the recovery time
         if (!reset_powerdown_n) wait_rec = 1'b1;
         if (req_ready && !rdy_prev && wait_rec) begin
            chk(rec >= RECOVERY_CYC, 1'b1);
            wait_rec = 1'b0;
         end
      end
      rp_prev = reset_powerdown_n;
      st_prev = status_pin;
      rdy_prev = req_ready;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      chk(1'b0, 1'b1);
      summarize();
   end

   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_op = OP_READ;
      req_addr = 24'h000000;
      req_wdata = 16'h0000;
      byte_mode = 1'b1;
      repeat (2) @(negedge mclk);
      chk({req_ready, reset_powerdown_n, output_enable_n, write_strobe_n,
         data_oe_n}, 5'b00111);
      repeat (14) @(negedge mclk);
      reset_n <= 1'b1;
      foreach (rows[i]) do_req(rows[i]);
      // reset while the state machine runs needs the long pulse
      n = 0;
      while (device_busy !== 1'b0 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      chk(device_busy, 1'b0);
      do_req('{OP_ARRAY_WRITE, 24'h7, 16'h5a5a, 1'b1, 16'h0});
      n = 0;
      while (device_busy !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      chk(device_busy, 1'b1);
      do_req('{OP_RESET, 24'h0, 16'h0, 1'b1, 16'h0});
      do_req('{OP_READ, 24'h7, 16'h0, 1'b1, 16'h5a5a});
      chk(device_busy, 1'b0);
      do_req('{OP_RESET, 24'h0, 16'h0, 1'b1, 16'h0});
      do_req('{OP_READ, 24'h2, 16'h0, 1'b0, 16'h0034});
      summarize();
   end
endmodule // async_flash_bus_control_tb
